// file: pkg/regfile_pkg.sv
// What this block does
// - Working registers sit at data addresses 0x00-0x1F
// - Pointers may address any working register
// - Top six registers form three 16-bit pointers
// - Pointers support displacement, post-increment, pre-decrement
// - Register operands read in one cycle
// - Stack grows toward lower addresses
// - Push lowers pointer by one, call by two
// - Pop raises pointer by one, return by two
// - Stack pointer bytes at I/O 0x3E/0x3D, reset zero
// - High stack byte may be omitted
// - One/two byte operands, byte or word result
package regfile_pkg;

    // ==========================================================
    // Register file layout
    localparam int          REG_COUNT         = 32;
    localparam logic [15:0] REGFILE_LAST_ADDR = 16'h001f;
    localparam logic [7:0]  REG_RESET         = 8'h00;
    localparam logic [4:0]  PTR_X_LOW         = 5'h1a;
    localparam logic [4:0]  PTR_Y_LOW         = 5'h1c;
    localparam logic [4:0]  PTR_Z_LOW         = 5'h1e;

    // ==========================================================
    // Stack pointer I/O registers
    localparam logic [15:0] IO_DATA_BASE      = 16'h0020;
    localparam logic [15:0] SP_LOW_IO         = 16'h003d;
    localparam logic [15:0] SP_HIGH_IO        = 16'h003e;
    localparam logic [15:0] SP_RESET          = 16'h0000;
    localparam logic [15:0] STACK_FLOOR       = 16'h0060;
    localparam logic [15:0] SINGLE_BYTE       = 16'h0001;
    localparam logic [15:0] RETURN_ADDR_BYTES = 16'h0002;

    // ==========================================================
    // Operation codes
    typedef enum logic [2:0] {
        SP_HOLD,
        SP_PUSH_BYTE,
        SP_PUSH_RETURN,
        SP_POP_BYTE,
        SP_POP_RETURN
    } sp_op_t;

    typedef enum logic [1:0] {
        PTR_PLAIN,
        PTR_DISP,
        PTR_POST_INC,
        PTR_PRE_DEC
    } ptr_mode_t;

endpackage : regfile_pkg

// file: verilog/pointer_step.sv
`timescale 1ns/10ps
module pointer_step
    import regfile_pkg::*;
(
    // Pointer and mode
    input  wire logic [15:0] ptr_i,
    input  wire ptr_mode_t   mode_i,
    input  wire logic [5:0]  disp_i,
    // Results
    output logic      [15:0] addr_o,
    output logic      [15:0] next_ptr_o,
    output logic             write_back_o
);

    // ==========================================================
    // Effective address and updated pointer
    // displacement, increment, decrement
    always_comb
    begin
        addr_o       = ptr_i;
        next_ptr_o   = ptr_i;
        write_back_o = 1'b0;
        unique case (mode_i)
            PTR_PLAIN:
            begin
                addr_o = ptr_i;
            end
            PTR_DISP:
            begin
                addr_o = 16'(ptr_i + {10'h000, disp_i});
            end
            PTR_POST_INC:
            begin
                next_ptr_o   = 16'(ptr_i + SINGLE_BYTE);
                write_back_o = 1'b1;
            end
            PTR_PRE_DEC:
            begin
                addr_o       = 16'(ptr_i - SINGLE_BYTE);
                next_ptr_o   = 16'(ptr_i - SINGLE_BYTE);
                write_back_o = 1'b1;
            end
        endcase
    end

endmodule : pointer_step

// file: verilog/cpu_register_file_stack_pointer.sv
`timescale 1ns/10ps
module cpu_register_file_stack_pointer
    import regfile_pkg::*;
#(
    parameter bit HAS_SP_HIGH = 1'b1
)
(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // Operand reads
    input  wire logic [4:0]  rd_a_addr_i,
    input  wire logic [4:0]  rd_b_addr_i,
    output logic      [7:0]  rd_a_data_o,
    output logic      [7:0]  rd_b_data_o,
    // Result write
    input  wire logic        wr_en_i,
    input  wire logic        wr_wide_i,
    input  wire logic [4:0]  wr_addr_i,
    input  wire logic [15:0] wr_data_i,
    // Data-space access
    input  wire logic        ds_en_i,
    input  wire logic        ds_we_i,
    input  wire logic [15:0] ds_addr_i,
    input  wire logic [7:0]  ds_wdata_i,
    output logic      [7:0]  ds_rdata_o,
    output logic             ds_hit_o,
    // Indirect pointer use
    input  wire logic        ptr_en_i,
    input  wire logic [1:0]  ptr_sel_i,
    input  wire ptr_mode_t   ptr_mode_i,
    input  wire logic [5:0]  ptr_disp_i,
    output logic      [15:0] ptr_addr_o,
    // Stack
    input  wire sp_op_t      sp_op_i,
    output logic      [15:0] stack_top_pointer_o
);

    // ==========================================================
    // Constants and storage
    localparam logic [15:0] SP_LOW_DATA  = 16'(IO_DATA_BASE + SP_LOW_IO);
    localparam logic [15:0] SP_HIGH_DATA = 16'(IO_DATA_BASE + SP_HIGH_IO);
    localparam logic [15:0] SP_MASK      = HAS_SP_HIGH ? 16'hffff : 16'h00ff;

    logic [7:0]  regs [REG_COUNT];
    logic [15:0] sp;
    logic [15:0] next_sp;
    logic [4:0]  pbase;
    logic [15:0] ptr_cur;
    logic [15:0] ptr_addr;
    logic [15:0] ptr_next;
    logic        ptr_wb;
    logic [15:0] ds_addr;
    logic        ds_store;
    logic        ds_load;
    logic        sp_io_store;

    // ==========================================================
    // Helpers
    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        case (sel)
            2'd0:    return PTR_X_LOW;
            2'd1:    return PTR_Y_LOW;
            default: return PTR_Z_LOW;
        endcase
    endfunction : ptr_base

    function automatic logic in_regfile(input logic [15:0] a);
        return a <= REGFILE_LAST_ADDR;
    endfunction : in_regfile

    // ==========================================================
    // Pointer selection and address
    // pointer from register pair
    assign pbase   = ptr_base(ptr_sel_i);
    assign ptr_cur = {regs[5'(pbase + 5'd1)], regs[pbase]};

    pointer_step u_step (
        .ptr_i        (ptr_cur),
        .mode_i       (ptr_mode_i),
        .disp_i       (ptr_disp_i),
        .addr_o       (ptr_addr),
        .next_ptr_o   (ptr_next),
        .write_back_o (ptr_wb)
    );

    // Data address, indirect when a pointer is used
    // pointer reaches any register
    assign ds_addr     = ptr_en_i ? ptr_addr : ds_addr_i;
    assign ds_store    = ds_en_i & ds_we_i;
    assign ds_load     = ds_en_i & ~ds_we_i;
    assign sp_io_store = ds_store & ((ds_addr == SP_LOW_DATA) | (HAS_SP_HIGH & (ds_addr == SP_HIGH_DATA)));

    // ==========================================================
    // Register array writes, later source overrides earlier
    // store after result write
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < REG_COUNT; i++)
                regs[i] <= REG_RESET;
        end
        else if (ce_i)
        begin
            if (wr_en_i)
            begin
                regs[wr_addr_i] <= wr_data_i[7:0];
                if (wr_wide_i)
                    regs[5'(wr_addr_i + 5'd1)] <= wr_data_i[15:8];
            end
            if (ptr_en_i && ptr_wb)
            begin
                regs[pbase]                <= ptr_next[7:0];
                regs[5'(pbase + 5'd1)]     <= ptr_next[15:8];
            end
            if (ds_store && in_regfile(ds_addr))
                regs[ds_addr[4:0]] <= ds_wdata_i;
        end
    end

    // ==========================================================
    // Stack pointer next value
    // push lowers pointer
    always_comb
    begin
        next_sp = sp;
        unique case (sp_op_i)
            SP_HOLD:        next_sp = sp;
            SP_PUSH_BYTE:   next_sp = 16'(sp - SINGLE_BYTE);
            SP_PUSH_RETURN: next_sp = 16'(sp - RETURN_ADDR_BYTES);
            SP_POP_BYTE:    next_sp = 16'(sp + SINGLE_BYTE);
            SP_POP_RETURN:  next_sp = 16'(sp + RETURN_ADDR_BYTES);
            default:        next_sp = sp;
        endcase
        if (ds_store && ds_addr == SP_LOW_DATA)
            next_sp[7:0] = ds_wdata_i;
        if (HAS_SP_HIGH && ds_store && ds_addr == SP_HIGH_DATA)
            next_sp[15:8] = ds_wdata_i;
        next_sp = next_sp & SP_MASK;
    end

    // Stack pointer register
    // pointer tracks stack top
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            sp <= SP_RESET;
        else if (ce_i)
            sp <= next_sp;
    end

    assign stack_top_pointer_o = sp;

    // ==========================================================
    // Registered operand reads
    // single-cycle operand access
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_a_data_o <= REG_RESET;
            rd_b_data_o <= REG_RESET;
            ptr_addr_o  <= 16'h0000;
        end
        else if (ce_i)
        begin
            rd_a_data_o <= regs[rd_a_addr_i];
            rd_b_data_o <= regs[rd_b_addr_i];
            if (ptr_en_i)
                ptr_addr_o <= ptr_addr;
        end
    end

    // Data-space read answer
    // loads from register addresses
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ds_rdata_o <= 8'h00;
            ds_hit_o   <= 1'b0;
        end
        else if (ce_i)
        begin
            ds_rdata_o <= 8'h00;
            ds_hit_o   <= 1'b0;
            if (ds_load && in_regfile(ds_addr))
            begin
                ds_rdata_o <= regs[ds_addr[4:0]];
                ds_hit_o   <= 1'b1;
            end
            else if (ds_load && ds_addr == SP_LOW_DATA)
            begin
                ds_rdata_o <= sp[7:0];
                ds_hit_o   <= 1'b1;
            end
            else if (ds_load && HAS_SP_HIGH && ds_addr == SP_HIGH_DATA)
            begin
                ds_rdata_o <= sp[15:8];
                ds_hit_o   <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    logic [7:0]  ds_reg_view;
    logic [7:0]  rd_a_view;
    logic [15:0] ptr_x;
    logic [15:0] ptr_y;
    logic [4:0]  wr_addr_q;

    assign ds_reg_view = regs[ds_addr[4:0]];
    assign rd_a_view   = regs[rd_a_addr_i];
    assign ptr_x       = {regs[5'(PTR_X_LOW + 5'd1)], regs[PTR_X_LOW]};
    assign ptr_y       = {regs[5'(PTR_Y_LOW + 5'd1)], regs[PTR_Y_LOW]};

    always_ff @(posedge clk_i)
    begin
        wr_addr_q <= wr_addr_i;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_push_return;
        ce_i && sp_op_i == SP_PUSH_RETURN && !sp_io_store;
    endsequence
    sequence s_pop_return;
        ce_i && sp_op_i == SP_POP_RETURN && !sp_io_store;
    endsequence

    a_sp_push_byte: assert property (
        ce_i && sp_op_i == SP_PUSH_BYTE && !sp_io_store |=> sp == (16'($past(sp) - 16'h0001) & SP_MASK))
        else $error("push did not lower stack pointer by one");
    a_sp_push_return: assert property (
        s_push_return |=> sp == (16'($past(sp) - 16'h0002) & SP_MASK))
        else $error("call did not lower stack pointer by two");
    a_sp_pop_byte: assert property (
        ce_i && sp_op_i == SP_POP_BYTE && !sp_io_store |=> sp == (16'($past(sp) + 16'h0001) & SP_MASK))
        else $error("pop did not raise stack pointer by one");
    a_sp_pop_return: assert property (
        s_pop_return |=> sp == (16'($past(sp) + 16'h0002) & SP_MASK))
        else $error("return did not raise stack pointer by two");
    a_sp_after_reset: assert property (
        $rose(rst_n_i) |-> stack_top_pointer_o == 16'h0000)
        else $error("stack pointer not zero after reset");
    a_sp_low_write: assert property (
        ce_i && ds_store && ds_addr == SP_LOW_DATA |=> sp[7:0] == $past(ds_wdata_i))
        else $error("stack pointer low byte store lost");
    a_sp_high_absent: assert property (
        !HAS_SP_HIGH |-> sp[15:8] == 8'h00)
        else $error("absent stack high byte is not zero");
    a_regfile_map: assert property (
        ce_i && !ptr_en_i && ds_load && in_regfile(ds_addr_i) |=> ds_hit_o && ds_rdata_o == $past(ds_reg_view))
        else $error("register address load missed register file");
    a_indirect_reg: assert property (
        ce_i && ptr_en_i && ds_load && in_regfile(ptr_addr) |=> ds_hit_o && ds_rdata_o == $past(ds_reg_view))
        else $error("indirect load missed register file");
    a_ptr_post_inc: assert property (
        ce_i && ptr_en_i && ptr_sel_i == 2'd0 && ptr_mode_i == PTR_POST_INC && !wr_en_i && !ds_store
        |=> ptr_x == 16'($past(ptr_x) + 16'h0001) && ptr_addr_o == $past(ptr_x))
        else $error("post-increment wrong");
    a_ptr_pre_dec: assert property (
        ce_i && ptr_en_i && ptr_mode_i == PTR_PRE_DEC |=> ptr_addr_o == 16'($past(ptr_cur) - 16'h0001))
        else $error("pre-decrement address wrong");
    a_ptr_y_disp: assert property (
        ce_i && ptr_en_i && ptr_sel_i == 2'd1 && ptr_mode_i == PTR_DISP
        |=> ptr_addr_o == 16'($past(ptr_y) + {10'h000, $past(ptr_disp_i)}))
        else $error("displacement address wrong");
    a_operand_read: assert property (
        ce_i |=> rd_a_data_o == $past(rd_a_view))
        else $error("operand read not ready next cycle");
    a_wide_result: assert property (
        ce_i && wr_en_i && wr_wide_i && !ptr_en_i && !ds_store
        |=> {regs[5'(wr_addr_q + 5'd1)], regs[wr_addr_q]} == $past(wr_data_i))
        else $error("word result not written to pair");
    a_store_wins: assert property (
        ce_i && wr_en_i && !wr_wide_i && !ptr_en_i && ds_store && ds_addr_i == {11'h000, wr_addr_i}
        |=> regs[wr_addr_q] == $past(ds_wdata_i))
        else $error("later store did not persist");

endmodule : cpu_register_file_stack_pointer

// file: test/cpu_datapath_model.sv
`timescale 1ns/10ps
module cpu_datapath_model
    import regfile_pkg::*;
(
    // Clock
    input  wire logic         clk_i,
    // Requests toward the register file
    output logic              ce_o,
    output logic       [4:0]  rd_a_addr_o,
    output logic       [4:0]  rd_b_addr_o,
    output logic              wr_en_o,
    output logic              wr_wide_o,
    output logic       [4:0]  wr_addr_o,
    output logic       [15:0] wr_data_o,
    output logic              ds_en_o,
    output logic              ds_we_o,
    output logic       [15:0] ds_addr_o,
    output logic       [7:0]  ds_wdata_o,
    output logic              ptr_en_o,
    output logic       [1:0]  ptr_sel_o,
    output ptr_mode_t         ptr_mode_o,
    output logic       [5:0]  ptr_disp_o,
    output sp_op_t            sp_op_o
);
    // ==========================================================
    // Idle request state at time zero
    initial
    begin
        {ce_o, rd_a_addr_o, rd_b_addr_o, wr_en_o, wr_wide_o, wr_addr_o, wr_data_o} = '0;
        {ds_en_o, ds_we_o, ds_addr_o, ds_wdata_o, ptr_en_o, ptr_sel_o, ptr_disp_o} = '0;
        ptr_mode_o = PTR_PLAIN;
        sp_op_o = SP_HOLD;
        ce_o = 1'b1;
    end

    // ==========================================================
    // Request tasks, fields change only at a rising edge
    task automatic at_edge();
        @(posedge clk_i);
    endtask : at_edge

    // Taken at this edge, strobes dropped, outputs settled
    task automatic go();
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        ds_en_o <= 1'b0;
        ptr_en_o <= 1'b0;
        sp_op_o <= SP_HOLD;
        #1;
    endtask : go

    task automatic rd(input logic [4:0] a, input logic [4:0] b);
        rd_a_addr_o <= a;
        rd_b_addr_o <= b;
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic wide);
        wr_en_o <= 1'b1;
        wr_wide_o <= wide;
        wr_addr_o <= a;
        wr_data_o <= d;
    endtask : wr

    task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d);
        ds_en_o <= 1'b1;
        ds_we_o <= we;
        ds_addr_o <= a;
        ds_wdata_o <= d;
    endtask : access

    task automatic ptr(input logic [1:0] sel, input ptr_mode_t mode, input logic [5:0] disp);
        access(1'b0, 16'h0000, 8'h00);
        ptr_en_o <= 1'b1;
        ptr_sel_o <= sel;
        ptr_mode_o <= mode;
        ptr_disp_o <= disp;
    endtask : ptr

    // stack set above floor before any push
    task automatic set_stack(input logic [15:0] v);
        at_edge();
        access(1'b1, 16'h005e, v[15:8]);
        go();
        at_edge();
        access(1'b1, 16'h005d, v[7:0]);
        go();
    endtask : set_stack
endmodule : cpu_datapath_model

// file: test/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
    import regfile_pkg::*;
    logic        clk_i, rst_n_i, ce, wr_en, wr_wide, ds_en, ds_we, ptr_en, hit, s_hit;
    logic [4:0]  rd_a, rd_b, wr_addr;
    logic [7:0]  rd_a_q, rd_b_q, ds_wd, ds_rd;
    logic [15:0] wr_data, ds_addr, ptr_addr, sp, s_sp, exp_sp;
    logic [1:0]  ptr_sel;
    logic [5:0]  ptr_disp;
    ptr_mode_t   ptr_mode;
    sp_op_t      sp_op;
    int          err_count = 0, total_checks = 0, cycles = 0;

    // ==========================================================
    // Clock and hang guard
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            end_sim();
        end
    end

    // ==========================================================
    // Partner, full device, device without high stack byte
    cpu_datapath_model u_dp (.clk_i(clk_i), .ce_o(ce), .rd_a_addr_o(rd_a), .rd_b_addr_o(rd_b),
        .wr_en_o(wr_en), .wr_wide_o(wr_wide), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .ds_en_o(ds_en),
        .ds_we_o(ds_we), .ds_addr_o(ds_addr), .ds_wdata_o(ds_wd), .ptr_en_o(ptr_en), .ptr_sel_o(ptr_sel),
        .ptr_mode_o(ptr_mode), .ptr_disp_o(ptr_disp), .sp_op_o(sp_op));
    cpu_register_file_stack_pointer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .rd_a_addr_i(rd_a),
        .rd_b_addr_i(rd_b), .rd_a_data_o(rd_a_q), .rd_b_data_o(rd_b_q), .wr_en_i(wr_en), .wr_wide_i(wr_wide),
        .wr_addr_i(wr_addr), .wr_data_i(wr_data), .ds_en_i(ds_en), .ds_we_i(ds_we), .ds_addr_i(ds_addr),
        .ds_wdata_i(ds_wd), .ds_rdata_o(ds_rd), .ds_hit_o(hit), .ptr_en_i(ptr_en), .ptr_sel_i(ptr_sel),
        .ptr_mode_i(ptr_mode), .ptr_disp_i(ptr_disp), .ptr_addr_o(ptr_addr), .sp_op_i(sp_op),
        .stack_top_pointer_o(sp));
    cpu_register_file_stack_pointer #(.HAS_SP_HIGH(1'b0)) u_small (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ce_i(ce), .rd_a_addr_i(rd_a), .rd_b_addr_i(rd_b), .rd_a_data_o(), .rd_b_data_o(), .wr_en_i(wr_en),
        .wr_wide_i(wr_wide), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .ds_en_i(ds_en), .ds_we_i(ds_we),
        .ds_addr_i(ds_addr), .ds_wdata_i(ds_wd), .ds_rdata_o(), .ds_hit_o(s_hit), .ptr_en_i(ptr_en),
        .ptr_sel_i(ptr_sel), .ptr_mode_i(ptr_mode), .ptr_disp_i(ptr_disp), .ptr_addr_o(), .sp_op_i(sp_op),
        .stack_top_pointer_o(s_sp));

    // ==========================================================
    // Shared steps
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] ea, input logic [4:0] b, input logic [7:0] eb);
        u_dp.at_edge();
        u_dp.rd(a, b);
        u_dp.go();
        `CHK(rd_a_q, ea)
        `CHK(rd_b_q, eb)
    endtask : rd_chk

    task automatic ld_chk(input logic [15:0] a, input logic h, input logic [7:0] e);
        u_dp.at_edge();
        u_dp.access(1'b0, a, 8'h00);
        u_dp.go();
        `CHK(hit, h)
        `CHK(ds_rd, e)
    endtask : ld_chk

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        `CHK(sp, 16'h0000)
        ld_chk(16'h005d, 1'b1, 8'h00);
        ld_chk(16'h005e, 1'b1, 8'h00);
    endtask : t_reset

    task automatic t_direct();
        for (int i = 0; i < 8; i++)
        begin
            u_dp.at_edge();
            u_dp.access(1'b1, 16'(i * 4 + 3), 8'(8'h5a ^ i));
            u_dp.go();
        end
        rd_chk(5'h03, 8'h5a, 5'h1f, 8'h5d);
        ld_chk(16'h001f, 1'b1, 8'h5d);
        ld_chk(16'h0020, 1'b0, 8'h00);
    endtask : t_direct

    task automatic t_stack();
        sp_op_t ops[4] = '{SP_PUSH_BYTE, SP_PUSH_RETURN, SP_POP_BYTE, SP_POP_RETURN};
        logic [15:0] step[4] = '{16'hffff, 16'hfffe, 16'h0001, 16'h0002};
        exp_sp = 16'h0180;
        u_dp.set_stack(exp_sp);
        `CHK(sp, exp_sp)
        `CHK(s_sp, 16'h0080)
        foreach (ops[i])
        begin
            u_dp.at_edge();
            u_dp.sp_op_o <= ops[i];
            u_dp.go();
            exp_sp = exp_sp + step[i];
            `CHK(sp, exp_sp)
            `CHK(s_sp, {8'h00, exp_sp[7:0]})
        end
        ld_chk(16'h005e, 1'b1, 8'h01);
        u_dp.at_edge();
        u_dp.access(1'b0, 16'h005e, 8'h00);
        u_dp.go();
        `CHK(s_hit, 1'b0)
    endtask : t_stack

    task automatic t_ptr();
        u_dp.at_edge();
        u_dp.wr(5'h1a, 16'h0005, 1'b1);
        u_dp.go();
        u_dp.at_edge();
        u_dp.wr(5'h1c, 16'h0010, 1'b1);
        u_dp.go();
        u_dp.at_edge();
        u_dp.wr(5'h1e, 16'h0003, 1'b1);
        u_dp.go();
        u_dp.at_edge();
        u_dp.access(1'b1, 16'h0005, 8'h77);
        u_dp.go();
        u_dp.at_edge();
        u_dp.ptr(2'd0, PTR_POST_INC, 6'h00);
        u_dp.go();
        `CHK(ptr_addr, 16'h0005)
        `CHK(ds_rd, 8'h77)
        rd_chk(5'h1a, 8'h06, 5'h1b, 8'h00);
        u_dp.at_edge();
        u_dp.ptr(2'd1, PTR_PRE_DEC, 6'h00);
        u_dp.go();
        `CHK(ptr_addr, 16'h000f)
        rd_chk(5'h1c, 8'h0f, 5'h1d, 8'h00);
        u_dp.at_edge();
        u_dp.ptr(2'd1, PTR_DISP, 6'h01);
        u_dp.go();
        `CHK(ptr_addr, 16'h0010)
        `CHK(ds_rd, 8'h00)
        u_dp.at_edge();
        u_dp.ptr(2'd2, PTR_DISP, 6'h02);
        u_dp.go();
        `CHK(ptr_addr, 16'h0005)
        `CHK(ds_rd, 8'h77)
        rd_chk(5'h1e, 8'h03, 5'h1f, 8'h00);
    endtask : t_ptr

    task automatic t_order();
        u_dp.at_edge();
        u_dp.wr(5'h03, 16'h0011, 1'b0);
        u_dp.access(1'b1, 16'h0003, 8'h22);
        u_dp.sp_op_o <= SP_PUSH_BYTE;
        u_dp.go();
        rd_chk(5'h03, 8'h22, 5'h1e, 8'h03);
        `CHK(sp, exp_sp - 16'h0001)
    endtask : t_order

    // Enable low: store and push both frozen
    task automatic t_hold();
        u_dp.at_edge();
        u_dp.ce_o <= 1'b0;
        u_dp.access(1'b1, 16'h0003, 8'h99);
        u_dp.sp_op_o <= SP_PUSH_BYTE;
        u_dp.go();
        u_dp.ce_o <= 1'b1;
        `CHK(sp, exp_sp - 16'h0001)
        `CHK(s_sp, 16'h007f)
        rd_chk(5'h03, 8'h22, 5'h1a, 8'h06);
    endtask : t_hold

    // ==========================================================
    // Main sequence
    initial
    begin
        rst_n_i = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        t_reset();
        t_direct();
        t_stack();
        t_ptr();
        t_order();
        t_hold();
        end_sim();
    end
endmodule : tb
